// [hw/vlf_map.svh]
// register map, field positions, line numbers and timing constants
`ifndef VLF_MAP_SVH
`define VLF_MAP_SVH
`define VLF_CLK_NS    50
`define VLF_LOSS_NS   128000
`define VLF_FINE_NS   37
`define VLF_FPH_MAX   100
`define VLF_A_GLOBAL  8'h00
`define VLF_A_STATUS  8'h04
`define VLF_R_CTRL    3'h0
`define VLF_R_HTIM    3'h1
`define VLF_R_FPH     3'h2
`define VLF_R_VTIM    3'h3
`define VLF_R_MASK1   3'h4
`define VLF_R_MASK2   3'h5
`define VLF_B_REMOTE  0
`define VLF_B_VSETUP  1
`define VLF_S_OK      0
`define VLF_S_HOLD    8
`define VLF_S_M625    16
`define VLF_S_FS      17
`define VLF_F_FRZ     2:0
`define VLF_B_TEST    3
`define VLF_B_KILL    4
`define VLF_B_BOFF    5
`define VLF_B_BYP     6
`define VLF_B_EDIS    7
`define VLF_B_ASET    8
`define VLF_B_BALL    9
`define VLF_F_LOW     12:0
`define VLF_F_PAIR    12:10
`define VLF_F_CLIP    14:13
`define VLF_CTRL_RST  15'h0300
`define VLF_MASK_RST  18'h3FFFF
`define VLF_FS_FRAME  2'h0
`define VLF_FS_F1     2'h1
`define VLF_FS_F2     2'h2
`define VLF_Y_BLACK   10'h040
`define VLF_C_ZERO    10'h200
`define VLF_BLUE_Y    10'h0A3
`define VLF_BLUE_C    10'h3C0
`define VLF_BAR_W     10'h05A
`define VLF_L5_F2S    10'h108
`define VLF_L5_FA1S   10'h019
`define VLF_L5_FA1E   10'h107
`define VLF_L5_FA2S   10'h120
`define VLF_L5_FA2E   10'h20D
`define VLF_L5_PA1S   10'h015
`define VLF_L5_PA1E   10'h018
`define VLF_L5_PA2S   10'h11C
`define VLF_L5_PA2E   10'h11F
`define VLF_L5_CV1S   10'h00A
`define VLF_L5_CV1E   10'h014
`define VLF_L5_CV2S   10'h111
`define VLF_L5_CV2E   10'h11B
`define VLF_L6_F2S    10'h137
`define VLF_L6_FA1S   10'h01D
`define VLF_L6_FA1E   10'h136
`define VLF_L6_FA2S   10'h156
`define VLF_L6_FA2E   10'h26F
`define VLF_L6_PA1S   10'h018
`define VLF_L6_PA1E   10'h01C
`define VLF_L6_PA2S   10'h151
`define VLF_L6_PA2E   10'h155
`define VLF_L6_CV1S   10'h006
`define VLF_L6_CV1E   10'h017
`define VLF_L6_CV2S   10'h13F
`define VLF_L6_CV2E   10'h150
`endif

// [hw/vlf_pkg.sv]
// shared types of the line and freeze control block
package vlf_pkg;
   typedef struct packed {
      logic       valid;
      logic [9:0] y;
      logic [9:0] c;
   } vlf_smp_t;
   typedef enum logic [2:0] {
      vlf_frz_blue, vlf_frz_hold, vlf_frz_f1, vlf_frz_f2, vlf_frz_frame
   } vlf_frz_t;
   typedef enum logic [1:0] {
      vlf_cls_fa, vlf_cls_pa, vlf_cls_cv, vlf_cls_fv
   } vlf_cls_t;
   typedef struct packed {
      logic        blank;
      logic        data_line;
      logic        setup;
      logic        burst_en;
      logic        proc_bypass;
      logic        enh_bypass;
      logic        enh_off;
      logic [1:0]  clip;
      logic        hold;
      logic [1:0]  fsel;
      logic [9:0]  vdly;
      logic [12:0] fine;
   } vlf_ctl_t;
endpackage

// [hw/vlf_chan.sv]
// one channel sample path: half-pixel delay, bars, blue, blank, chroma kill, loss detect
`timescale 1ns/100ps
`include "vlf_map.svh"
module vlf_chan #(
   parameter int AW       = 10,
   parameter int LOSS_CYC = (`VLF_LOSS_NS + `VLF_CLK_NS - 1) / `VLF_CLK_NS
)(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire vlf_pkg::vlf_smp_t in_smp,
   input  wire logic              pix_en,
   input  wire logic              line_start,
   input  wire logic [AW:0]       hdly,
   input  wire logic              test_on,
   input  wire logic              kill,
   input  wire logic              blank,
   input  wire logic              blue_on,
   output vlf_pkg::vlf_smp_t      out_smp,
   output logic                   sig_ok
);
   localparam int LW = $clog2(LOSS_CYC + 1);
   localparam logic [LW-1:0] LOSS_LAST = LW'(LOSS_CYC - 1);
   localparam logic [9:0] BAR_Y [8] = '{10'h2D1, 10'h2A0, 10'h244, 10'h213,
                                        10'h14E, 10'h11D, 10'h0C1, 10'h040};
   localparam logic [9:0] BAR_C [8] = '{10'h200, 10'h190, 10'h2B0, 10'h240,
                                        10'h1C0, 10'h150, 10'h270, 10'h200};
   logic [19:0]    mem [2**AW];
   logic [AW-1:0]  wp;
   logic [AW-1:0]  k;
   logic [19:0]    tap0;
   logic [19:0]    tap1;
   logic [9:0]     dly_y;
   logic [9:0]     dly_c;
   logic [9:0]     hcnt;
   logic [9:0]     bidx;
   logic [2:0]     bar;
   logic [LW-1:0]  loss_cnt;
   logic [9:0]     next_y;
   logic [9:0]     next_c;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   function automatic logic [9:0] avg(input logic [9:0] a, input logic [9:0] b);
      logic [10:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[10:1];
   endfunction

   always_ff @(posedge ref_clk) begin
      if (in_smp.valid) begin
         mem[wp] <= {in_smp.y, in_smp.c};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wp <= '0;
      end else if (in_smp.valid) begin
         wp <= wp + 1'b1;
      end
   end

   // whole pixels from the upper bits, odd half pixel by averaging neighbours
   always_comb begin
      k = hdly[AW:1];
      tap0 = (k == '0) ? {in_smp.y, in_smp.c} : mem[AW'(wp - k)];
      tap1 = mem[AW'(wp - k - 1'b1)];
      dly_y = hdly[0] ? avg(tap0[19:10], tap1[19:10]) : tap0[19:10];
      dly_c = hdly[0] ? avg(tap0[9:0], tap1[9:0]) : tap0[9:0];
   end

   always_ff @(posedge ref_clk) begin
      if (srst || line_start) begin
         hcnt <= '0;
      end else if (pix_en) begin
         hcnt <= hcnt + 1'b1;
      end
   end

   assign bidx = hcnt / `VLF_BAR_W;
   assign bar  = (bidx[9:3] != '0) ? 3'h7 : bidx[2:0];

   // loss is judged on this channel's own stream only
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         loss_cnt <= '0;
         sig_ok <= 1'b0;
      end else if (in_smp.valid) begin
         loss_cnt <= '0;
         sig_ok <= 1'b1;
      end else if (loss_cnt == LOSS_LAST) begin
         sig_ok <= 1'b0;
      end else begin
         loss_cnt <= loss_cnt + 1'b1;
      end
   end

   // bars ignore blanking and loss so the pattern stays a clean reference
   always_comb begin
      if (test_on) begin
         next_y = BAR_Y[bar];
         next_c = BAR_C[bar];
      end else if (blue_on && !sig_ok) begin
         next_y = `VLF_BLUE_Y;
         next_c = `VLF_BLUE_C;
      end else if (blank) begin
         next_y = `VLF_Y_BLACK;
         next_c = `VLF_C_ZERO;
      end else begin
         next_y = dly_y;
         next_c = dly_c;
      end
      if (kill) begin
         next_c = `VLF_C_ZERO;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         out_smp <= '0;
      end else begin
         out_smp.valid <= pix_en;
         if (pix_en) begin
            out_smp.y <= next_y;
            out_smp.c <= next_c;
         end
      end
   end

   sequence s_loss_edge;
      (loss_cnt == LOSS_LAST) && !in_smp.valid;
   endsequence
   property p_loss;
      s_loss_edge |=> !sig_ok;
   endproperty
   chk_loss_flag: assert property (p_loss)
      else $error("input loss not flagged after timeout");
   chk_blue_out: assert property (pix_en && blue_on && !sig_ok && !test_on |=>
      out_smp.y == `VLF_BLUE_Y)
      else $error("blue screen missing on input loss");
   chk_bars_out: assert property (pix_en && test_on |=>
      out_smp.y == BAR_Y[$past(bar)])
      else $error("colour bar level wrong");
endmodule

// [hw/vlf_top.sv]
// four-channel vbi line classing, freeze selection and output timing control
`timescale 1ns/100ps
`include "vlf_map.svh"
module vlf_top #(
   parameter int CH         = 4,
   parameter bit FS_VARIANT = 1'b1,
   parameter int AW         = 10,
   parameter int LOSS_CYC   = (`VLF_LOSS_NS + `VLF_CLK_NS - 1) / `VLF_CLK_NS
)(
   input  wire logic                       ref_clk,
   input  wire logic                       srst,
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic [31:0]                     reg_rdata,
   input  wire logic                       mode_625,
   input  wire logic                       pix_en,
   input  wire logic                       line_start,
   input  wire logic [9:0]                 line_num,
   input  wire vlf_pkg::vlf_smp_t [CH-1:0] vid_in,
   output vlf_pkg::vlf_smp_t [CH-1:0]      vid_out,
   output vlf_pkg::vlf_ctl_t [CH-1:0]      ctl_out
);
   logic                remote;
   logic                vsetup;
   logic [14:0]         ctrl [CH];
   vlf_pkg::vlf_frz_t   frz [CH];
   logic [AW:0]         htim [CH];
   logic [6:0]          fph [CH];
   logic [9:0]          vtim [CH];
   logic [17:0]         mask1 [CH];
   logic [17:0]         mask2 [CH];
   logic [CH-1:0]       sig_ok;
   logic [CH-1:0]       hold_v;
   logic                acc_ok;
   logic [2:0]          rsel;
   logic [31:0]         next_rdata;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   function automatic logic inr(input logic [9:0] n, input logic [9:0] lo,
                                input logic [9:0] hi);
      return (n >= lo) && (n <= hi);
   endfunction

   // anything outside the three listed ranges is fixed blanking, incl. the 625 wrap
   function automatic vlf_pkg::vlf_cls_t lcls(input logic m6, input logic [9:0] n);
      if (!m6) begin
         if (inr(n, `VLF_L5_FA1S, `VLF_L5_FA1E) || inr(n, `VLF_L5_FA2S, `VLF_L5_FA2E))
            return vlf_pkg::vlf_cls_fa;
         if (inr(n, `VLF_L5_PA1S, `VLF_L5_PA1E) || inr(n, `VLF_L5_PA2S, `VLF_L5_PA2E))
            return vlf_pkg::vlf_cls_pa;
         if (inr(n, `VLF_L5_CV1S, `VLF_L5_CV1E) || inr(n, `VLF_L5_CV2S, `VLF_L5_CV2E))
            return vlf_pkg::vlf_cls_cv;
      end else begin
         if (inr(n, `VLF_L6_FA1S, `VLF_L6_FA1E) || inr(n, `VLF_L6_FA2S, `VLF_L6_FA2E))
            return vlf_pkg::vlf_cls_fa;
         if (inr(n, `VLF_L6_PA1S, `VLF_L6_PA1E) || inr(n, `VLF_L6_PA2S, `VLF_L6_PA2E))
            return vlf_pkg::vlf_cls_pa;
         if (inr(n, `VLF_L6_CV1S, `VLF_L6_CV1E) || inr(n, `VLF_L6_CV2S, `VLF_L6_CV2E))
            return vlf_pkg::vlf_cls_cv;
      end
      return vlf_pkg::vlf_cls_fv;
   endfunction

   assign acc_ok = (reg_addr[1:0] == 2'h0);
   assign rsel   = reg_addr[4:2];

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         remote <= 1'b0;
         vsetup <= 1'b0;
      end else if (reg_wr && reg_addr == `VLF_A_GLOBAL) begin
         remote <= reg_wdata[`VLF_B_REMOTE];
         vsetup <= reg_wdata[`VLF_B_VSETUP];
      end
   end

   always_comb begin
      next_rdata = '0;
      if (reg_addr == `VLF_A_GLOBAL) begin
         next_rdata[`VLF_B_REMOTE] = remote;
         next_rdata[`VLF_B_VSETUP] = vsetup;
      end else if (reg_addr == `VLF_A_STATUS) begin
         next_rdata[`VLF_S_OK +: CH] = sig_ok;
         next_rdata[`VLF_S_HOLD +: CH] = hold_v;
         next_rdata[`VLF_S_M625] = mode_625;
         next_rdata[`VLF_S_FS] = FS_VARIANT;
      end
      for (int c = 0; c < CH; c++) begin
         if (acc_ok && reg_addr[7:5] == 3'(c + 1)) begin
            case (rsel)
               `VLF_R_CTRL:  next_rdata[14:0] = {ctrl[c][14:3], frz[c]};
               `VLF_R_HTIM:  next_rdata[AW:0] = htim[c];
               `VLF_R_FPH:   next_rdata[6:0] = fph[c];
               `VLF_R_VTIM:  next_rdata[9:0] = vtim[c];
               `VLF_R_MASK1: next_rdata[17:0] = mask1[c];
               `VLF_R_MASK2: next_rdata[17:0] = mask2[c];
               default:      next_rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : '0;
      end
   end

   for (genvar c = 0; c < CH; c++) begin : g_ch
      logic               wr_ch;
      vlf_pkg::vlf_cls_t  cls;
      logic               f2;
      logic               rsv;
      logic               cvb;
      logic               vbi;
      logic               blank;
      logic               setup;
      logic               hold;
      logic               blue;
      logic [1:0]         fsel;
      logic [9:0]         paoff;
      logic [9:0]         cvoff;
      logic               last_f2;

      assign wr_ch = reg_wr && acc_ok && (reg_addr[7:5] == 3'(c + 1));

      always_ff @(posedge ref_clk) begin
         if (srst) begin
            ctrl[c]  <= `VLF_CTRL_RST;
            frz[c]   <= vlf_pkg::vlf_frz_blue;
            htim[c]  <= '0;
            fph[c]   <= '0;
            vtim[c]  <= '0;
            mask1[c] <= `VLF_MASK_RST;
            mask2[c] <= `VLF_MASK_RST;
         end else if (wr_ch) begin
            case (rsel)
               `VLF_R_CTRL: begin
                  // clip level keeps its value unless written over the remote path
                  ctrl[c] <= {remote ? reg_wdata[`VLF_F_CLIP] : ctrl[c][`VLF_F_CLIP],
                              reg_wdata[`VLF_F_LOW]};
                  // illegal freeze codes are dropped so one choice always stands
                  if (reg_wdata[`VLF_F_FRZ] <= 3'(vlf_pkg::vlf_frz_frame)) begin
                     frz[c] <= vlf_pkg::vlf_frz_t'(reg_wdata[`VLF_F_FRZ]);
                  end
               end
               `VLF_R_HTIM: htim[c] <= reg_wdata[AW:0];
               `VLF_R_FPH: begin
                  fph[c] <= (reg_wdata > `VLF_FPH_MAX) ? 7'(`VLF_FPH_MAX)
                                                       : reg_wdata[6:0];
               end
               `VLF_R_VTIM: begin
                  if (FS_VARIANT) begin
                     vtim[c] <= reg_wdata[9:0];
                  end
               end
               `VLF_R_MASK1: mask1[c] <= reg_wdata[17:0];
               `VLF_R_MASK2: mask2[c] <= reg_wdata[17:0];
               default: ;
            endcase
         end
      end

      always_comb begin
         cls = lcls(mode_625, line_num);
         f2 = line_num >= (mode_625 ? `VLF_L6_F2S : `VLF_L5_F2S);
         if (mode_625) begin
            paoff = line_num - (f2 ? `VLF_L6_PA2S : `VLF_L6_PA1S);
            cvoff = line_num - (f2 ? `VLF_L6_CV2S : `VLF_L6_CV1S);
         end else begin
            paoff = line_num - (f2 ? `VLF_L5_PA2S : `VLF_L5_PA1S);
            cvoff = line_num - (f2 ? `VLF_L5_CV2S : `VLF_L5_CV1S);
         end
         rsv = (cls == vlf_pkg::vlf_cls_pa) && (paoff < 10'(ctrl[c][`VLF_F_PAIR]));
         if (remote) begin
            cvb = f2 ? mask2[c][cvoff[4:0]] : mask1[c][cvoff[4:0]];
         end else begin
            cvb = ctrl[c][`VLF_B_BALL];
         end
         blank = (cls == vlf_pkg::vlf_cls_fv) || ((cls == vlf_pkg::vlf_cls_cv) && cvb);
         vbi = (cls == vlf_pkg::vlf_cls_cv) || (cls == vlf_pkg::vlf_cls_fv);
         setup = ctrl[c][`VLF_B_ASET] && (!vbi || (vsetup && !mode_625));
         hold = 1'b0;
         blue = 1'b0;
         fsel = `VLF_FS_FRAME;
         if (FS_VARIANT) begin
            unique case (frz[c])
               vlf_pkg::vlf_frz_blue: begin
                  hold = !sig_ok[c];
                  blue = 1'b1;
               end
               vlf_pkg::vlf_frz_hold: begin
                  hold = !sig_ok[c];
                  fsel = last_f2 ? `VLF_FS_F2 : `VLF_FS_F1;
               end
               vlf_pkg::vlf_frz_f1: begin
                  hold = 1'b1;
                  fsel = `VLF_FS_F1;
               end
               vlf_pkg::vlf_frz_f2: begin
                  hold = 1'b1;
                  fsel = `VLF_FS_F2;
               end
               vlf_pkg::vlf_frz_frame: hold = 1'b1;
            endcase
         end
      end

      // field of the latest line seen while this channel's input was good
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            last_f2 <= 1'b0;
         end else if (line_start && sig_ok[c]) begin
            last_f2 <= f2;
         end
      end

      always_ff @(posedge ref_clk) begin
         if (srst) begin
            ctl_out[c] <= '0;
         end else begin
            ctl_out[c].blank       <= blank;
            ctl_out[c].data_line   <= rsv;
            ctl_out[c].setup       <= setup;
            ctl_out[c].burst_en    <= !ctrl[c][`VLF_B_BOFF];
            ctl_out[c].proc_bypass <= ctrl[c][`VLF_B_TEST];
            ctl_out[c].enh_bypass  <= ctrl[c][`VLF_B_BYP];
            ctl_out[c].enh_off     <= ctrl[c][`VLF_B_EDIS];
            ctl_out[c].clip        <= ctrl[c][`VLF_F_CLIP];
            ctl_out[c].hold        <= hold;
            ctl_out[c].fsel        <= fsel;
            ctl_out[c].vdly        <= vtim[c];
            ctl_out[c].fine        <= 13'(fph[c]) * 13'(`VLF_FINE_NS);
         end
      end

      assign hold_v[c] = ctl_out[c].hold;

      vlf_chan #(
         .AW       (AW),
         .LOSS_CYC (LOSS_CYC)
      ) u_chan (
         .ref_clk    (ref_clk),
         .srst       (srst),
         .in_smp     (vid_in[c]),
         .pix_en     (pix_en),
         .line_start (line_start),
         .hdly       (htim[c]),
         .test_on    (ctrl[c][`VLF_B_TEST]),
         .kill       (ctrl[c][`VLF_B_KILL]),
         .blank      (blank),
         .blue_on    (blue),
         .out_smp    (vid_out[c]),
         .sig_ok     (sig_ok[c])
      );

      chk_fixed_blank: assert property (cls == vlf_pkg::vlf_cls_fv |=> ctl_out[c].blank)
         else $error("fixed blanking line not blanked");
      chk_active_pic: assert property (cls == vlf_pkg::vlf_cls_fa |=>
         !ctl_out[c].blank && !ctl_out[c].data_line)
         else $error("fixed active line not carrying picture");
      chk_pair_first: assert property (cls == vlf_pkg::vlf_cls_pa && paoff == '0 &&
         ctrl[c][`VLF_F_PAIR] != '0 |=> ctl_out[c].data_line)
         else $error("first data pair not reserved");
      chk_pair_none: assert property (ctrl[c][`VLF_F_PAIR] == '0 |=>
         !ctl_out[c].data_line)
         else $error("line reserved with no pair chosen");
      chk_local_blank: assert property (cls == vlf_pkg::vlf_cls_cv && !remote |=>
         ctl_out[c].blank == $past(ctrl[c][`VLF_B_BALL]))
         else $error("local blanking setting not applied");
      chk_setup_gate: assert property (!ctrl[c][`VLF_B_ASET] |=> !ctl_out[c].setup)
         else $error("setup present while active setup is off");
      chk_setup_625: assert property (mode_625 && vbi |=> !ctl_out[c].setup)
         else $error("vbi setup applied in 625 mode");
      chk_clip_remote: assert property (wr_ch && rsel == `VLF_R_CTRL && !remote |=>
         $stable(ctrl[c][`VLF_F_CLIP]))
         else $error("black clip changed outside remote mode");
      chk_manual_f1: assert property (FS_VARIANT && frz[c] == vlf_pkg::vlf_frz_f1 |=>
         ctl_out[c].hold && ctl_out[c].fsel == `VLF_FS_F1)
         else $error("field one freeze not held");
      chk_fine_max: assert property (fph[c] <= 7'(`VLF_FPH_MAX))
         else $error("fine phase above full scale");
   end
endmodule

// [testbench/vlf_enc_model.sv]
// composite encoder sink model: latches the channel 0 samples it is handed
`timescale 1ns/100ps
module vlf_enc_model (
   input  wire logic                    ref_clk,
   input  wire vlf_pkg::vlf_smp_t [3:0] vid,
   output logic [9:0]                   last_y,
   output logic [9:0]                   last_c
);
   // only qualified samples count; y and c between strobes carry no meaning
   always @(posedge ref_clk) begin
      if (vid[0].valid) begin
         last_y <= vid[0].y;
         last_c <= vid[0].c;
      end
   end
endmodule

// [testbench/testbench.sv]
// self-checking bench of the line and freeze control block
`timescale 1ns/100ps
`include "vlf_map.svh"
module testbench;
   logic                    ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, feed = 0;
   logic                    mode_625 = 0, pix_en = 0, line_start = 0;
   logic [7:0]              reg_addr = 8'h00;
   logic [31:0]             reg_wdata = 32'h0, reg_rdata;
   logic [9:0]              line_num = 10'h001, last_y, last_c;
   vlf_pkg::vlf_smp_t [3:0] vid_in = '0, vid_out;
   vlf_pkg::vlf_ctl_t [3:0] ctl_out;
   int                      failures = 0, comparisons = 0, seed = 32'h4416;
   int                      k, l, n, c, m, f;
   int                      tbl[$] = '{9, 10, 20, 21, 23, 24, 25, 263, 264, 272, 273, 283, 286,
                                       287, 288, 525, 1005, 1006, 1023, 1024, 1026, 1029,
                                       1310, 1311, 1318, 1319, 1341, 1342, 1623, 1624, 1625};
   vlf_top #(.LOSS_CYC(16)) vlf_top_i (
      .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_625(mode_625),
      .pix_en(pix_en), .line_start(line_start), .line_num(line_num), .vid_in(vid_in),
      .vid_out(vid_out), .ctl_out(ctl_out));
   vlf_enc_model vlf_enc_model_i (.ref_clk(ref_clk), .vid(vid_out), .last_y(last_y),
      .last_c(last_c));
   always #25 ref_clk = ~ref_clk;
   // only channel 1 runs free; channel 0 is fed by hand for the delay check at the end
   always @(posedge ref_clk) vid_in[1] <= feed ? {1'b1, 10'($random(seed)), 10'h200} : '0;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic ln(input int n, input int m = 0);
      @(posedge ref_clk);
      line_num <= 10'(n);
      mode_625 <= m[0];
      line_start <= 1'b1;
      @(posedge ref_clk);
      line_start <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic px;
      @(posedge ref_clk);
      pix_en <= 1'b1;
      @(posedge ref_clk);
      pix_en <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   function automatic int cls(input int n, input int m);
      if (m) begin
         if (n <= 5 || n >= 624 || (n >= 311 && n <= 318)) return 3;
         if (n <= 23 || (n >= 319 && n <= 336)) return 2;
         return (n <= 28 || (n >= 337 && n <= 341)) ? 1 : 0;
      end
      if (n <= 9 || (n >= 264 && n <= 272)) return 3;
      if (n <= 20 || (n >= 273 && n <= 283)) return 2;
      return (n <= 24 || (n >= 284 && n <= 287)) ? 1 : 0;
   endfunction
   initial begin
      #2000000;
      chk(0, 1);
      test_done;
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      rc(8'h20, 32'h00000300);
      rc(8'h30, 32'h0003FFFF);
      rc(8'h04, 32'h00020F00);
      wr(8'h08, 32'hFFFFFFFF);
      rc(8'h08, 32'h00000000);
      for (k = 2; k < 5; k++) begin
         wr(8'h20, 32'h0300 | k);
         ln(100);
         chk(ctl_out[0].hold, 1);
         chk(ctl_out[0].fsel, k == 2 ? 1 : k == 3 ? 2 : 0);
      end
      wr(8'h20, 32'h0307);
      rc(8'h20, 32'h0304);
      for (int it = 0; it < 2; it++) begin
         wr(8'h00, 32'(it * 2));
         wr(8'h20, it ? 32'h0100 : 32'h0F00);
         for (k = 0; k < tbl.size() + 60; k++) begin
            if (k < tbl.size())
               l = tbl[k];
            else begin
               m = $unsigned($random(seed)) % 2;
               l = m * 1000 + 1 + $unsigned($random(seed)) % (m ? 625 : 525);
            end
            m = l > 1000;
            n = l % 1000;
            ln(n, m);
            c = cls(n, m);
            f = m ? (n > 300 ? 337 : 24) : (n > 200 ? 284 : 21);
            chk(ctl_out[0].blank, c == 3 || (c == 2 && it == 0));
            chk(ctl_out[0].data_line, c == 1 && it == 0 && n - f < 3);
            chk(ctl_out[0].setup, c < 2 || (it == 1 && !m));
         end
      end
      wr(8'h20, 32'h0378);
      px;
      chk(ctl_out[0].proc_bypass, 1);
      chk(ctl_out[0].burst_en, 0);
      chk({ctl_out[0].enh_bypass, ctl_out[0].enh_off}, 2'h2);
      chk(last_c, `VLF_C_ZERO);
      wr(8'h20, 32'h0380);
      ln(100);
      chk({ctl_out[0].burst_en, ctl_out[0].enh_bypass, ctl_out[0].enh_off}, 3'h5);
      chk(ctl_out[0].proc_bypass, 0);
      wr(8'h20, 32'h0300);
      wr(8'h40, 32'h0301);
      feed <= 1'b1;
      ln(100);
      px;
      chk(last_y, `VLF_BLUE_Y);
      chk(last_c, `VLF_BLUE_C);
      rc(8'h04, 32'h00020D02);
      // a field-two line while the input is good, so the hold must pick field two
      ln(300);
      feed <= 1'b0;
      for (k = 0; k < 40 && ctl_out[1].hold !== 1'b1; k++) #50;
      chk(k < 40, 1);
      chk(ctl_out[1].fsel, `VLF_FS_F2);
      if (k == 40)
         test_done;
      wr(8'h20, 32'h6300);
      ln(10);
      chk(ctl_out[0].clip, 0);
      wr(8'h00, 32'h1);
      wr(8'h20, 32'h6300);
      wr(8'h30, 32'h1);
      ln(10);
      chk(ctl_out[0].clip, 3);
      chk(ctl_out[0].blank, 1);
      ln(11);
      chk(ctl_out[0].blank, 0);
      wr(8'h28, 32'h96);
      rc(8'h28, 32'h64);
      chk(ctl_out[0].fine, 13'hE74);
      wr(8'h2C, 32'h7);
      ln(300);
      chk(ctl_out[0].vdly, 7);
      // three half pixels: output lies midway between the two previous samples
      wr(8'h24, 32'h3);
      vid_in[0] <= {1'b1, 10'h100, 10'h200};
      @(posedge ref_clk);
      vid_in[0] <= {1'b1, 10'h104, 10'h200};
      @(posedge ref_clk);
      vid_in[0] <= {1'b1, 10'h108, 10'h200};
      pix_en <= 1'b1;
      @(posedge ref_clk);
      vid_in[0] <= '0;
      pix_en <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk(last_y, (32'h100 + 32'h104) / 2);
      chk(last_c, `VLF_C_ZERO);
      test_done;
   end
endmodule
